//--- orcd_pkg.sv
// package: constants, field layout and types of the start-up configuration decoder
`default_nettype none
package orcd_pkg;
  // timing: system clock and the shortest instruction cycle
  localparam int CLK_PERIOD_PS = 10000;
  localparam int INSTR_CYCLE_MIN_PS = 62500;
  localparam int INSTR_CYCLE_MIN_CYC = (INSTR_CYCLE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int QUARTER_MIN_CYC = (INSTR_CYCLE_MIN_CYC + 3) / 4;
  localparam logic [7:0] QUARTER_MIN = 8'(QUARTER_MIN_CYC);

  // modelled oscillator time-base periods, in clk cycles
  localparam logic [7:0] OSCP_FASTRC = 8'h04;
  localparam logic [7:0] OSCP_FASTRC_PLL = 8'h02;
  localparam logic [7:0] OSCP_PRIMARY = 8'h06;
  localparam logic [7:0] OSCP_PRIMARY_PLL = 8'h02;
  localparam logic [7:0] OSCP_SECOSC = 8'h40;
  localparam logic [7:0] OSCP_LOWPWR_RC = 8'h80;
  localparam logic [7:0] OSCP_LOWPWR_FASTRC = 8'h20;
  localparam logic [7:0] OSCP_FASTRC_DIV = 8'h08;

  // register port addresses
  localparam logic [3:0] ADDR_OSC_NV = 4'h0;
  localparam logic [3:0] ADDR_RST_NV = 4'h1;
  localparam logic [3:0] ADDR_OSC_ACT = 4'h2;
  localparam logic [3:0] ADDR_RST_ACT = 4'h3;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h5;

  // osc_select_config fields
  localparam int OSC_TWO_SPEED_BIT = 7;
  localparam int OSC_LOWPOWER_RC_OSC_POWER_BIT = 6;
  localparam int OSC_SEC_SRC_BIT = 5;
  localparam int OSC_SEL_LSB = 0;
  localparam logic [7:0] OSC_IMPL_MASK = 8'hE7;
  localparam logic [7:0] OSC_ERASED = 8'hE1;

  // reset_config fields
  localparam int RST_MCLR_EN_BIT = 7;
  localparam int RST_TRIP_LSB = 5;
  localparam int RST_I2C_MAP_BIT = 4;
  localparam int RST_PWRUP_BIT = 3;
  localparam int RST_MODE_LSB = 0;
  localparam logic [7:0] RST_IMPL_MASK = 8'hFB;
  localparam logic [7:0] RST_ERASED = 8'hFB;

  // control and status fields
  localparam int CTRL_SW_BROWNOUT_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int STAT_HV_BIT = 0;
  localparam int STAT_LV_BIT = 1;
  localparam int STAT_REJECT_BIT = 2;
  localparam int STAT_BROWNOUT_BIT = 3;
  localparam int STAT_EXTRST_BIT = 4;

  typedef enum logic [2:0] {
    OSRC_FASTRC = 3'h0,
    OSRC_FASTRC_DIV_PLL = 3'h1,
    OSRC_PRIMARY = 3'h2,
    OSRC_PRIMARY_PLL = 3'h3,
    OSRC_SECOSC = 3'h4,
    OSRC_LOWPWR_RC = 3'h5,
    OSRC_LOWPWR_FASTRC_DIV = 3'h6,
    OSRC_FASTRC_DIV = 3'h7
  } orcd_osc_src_t;

  typedef enum logic [1:0] {
    TRIP_LOWPWR = 2'h0,
    TRIP_HIGH = 2'h1,
    TRIP_MIDDLE = 2'h2,
    TRIP_LOW = 2'h3
  } orcd_trip_t;

  typedef enum logic [1:0] {
    BMODE_OFF = 2'h0,
    BMODE_SOFTWARE = 2'h1,
    BMODE_AWAKE = 2'h2,
    BMODE_ALWAYS = 2'h3
  } orcd_bmode_t;

  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } orcd_phase_t;

  typedef struct packed {
    orcd_osc_src_t src;
    logic usePll;
    logic usePostscaler;
    logic twoSpeed;
    logic lowpwrRcHighPower;
    logic secOscCrystal;
  } orcd_osc_cfg_t;

  typedef struct packed {
    logic masterClearEn;
    orcd_trip_t trip;
    logic tripLowPower;
    logic i2cDefaultPins;
    logic powerupTimerEn;
    orcd_bmode_t mode;
    logic brownoutActive;
  } orcd_rst_cfg_t;
endpackage
`default_nettype wire

//--- orcd_pin_sync.sv
// module: three-stage pin synchroniser, a change counts once stages two and three agree
`default_nettype none
module orcd_pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [WIDTH-1:0] pinIn, // asynchronous pin levels
  output logic [WIDTH-1:0] pinOut // filtered levels
);
  logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, out_ff;
  logic [WIDTH-1:0] nxt_out;

  // per bit: accept the level only when the last two stages agree
  // in reset the output follows stage three, so release shows no false edge
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        nxt_out[i] = (!rst_n || (s2_ff[i] == s3_ff[i])) ? s3_ff[i] : out_ff[i];
      end
    end
  endgenerate

  // synchroniser stages keep sampling through reset
  always_ff @(posedge clk) begin
    s1_ff <= pinIn;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
    out_ff <= nxt_out;
  end

  assign pinOut = out_ff;
endmodule
`default_nettype wire

//--- orcd_cycle_gen.sv
// module: quarter-phase sequencer, instruction-cycle start and system clock output
`default_nettype none
module orcd_cycle_gen
  import orcd_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [7:0] quarterDiv, // clk cycles per quarter phase
  output orcd_phase_t phase, // current quarter phase
  output logic instrCycleStart, // pulse on entry to Q1
  output logic sysclkOut // low in Q1-Q2, high in Q3-Q4
);
  logic [7:0] divCnt_ff, nxt_divCnt;
  orcd_phase_t phase_ff, nxt_phase;
  logic start_ff, nxt_start;
  logic clkOut_ff, nxt_clkOut;
  logic tick;

  // divider: one enable per quarter, four quarters per cycle
  always_comb begin
    tick = (divCnt_ff >= quarterDiv - 8'h01);
    nxt_divCnt = tick ? 8'h00 : divCnt_ff + 8'h01;
    nxt_phase = phase_ff;
    if (tick) begin
      unique case (phase_ff)
        PH_Q1: nxt_phase = PH_Q2;
        PH_Q2: nxt_phase = PH_Q3;
        PH_Q3: nxt_phase = PH_Q4;
        PH_Q4: nxt_phase = PH_Q1;
        default: nxt_phase = PH_Q1;
      endcase
    end
    nxt_start = tick && (phase_ff == PH_Q4);
    nxt_clkOut = (nxt_phase == PH_Q3) || (nxt_phase == PH_Q4);
  end

  // phase state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt_ff <= 8'h00;
      phase_ff <= PH_Q4;
      start_ff <= 1'b0;
      clkOut_ff <= 1'b1;
    end else begin
      divCnt_ff <= nxt_divCnt;
      phase_ff <= nxt_phase;
      start_ff <= nxt_start;
      clkOut_ff <= nxt_clkOut;
    end
  end

  assign phase = phase_ff;
  assign instrCycleStart = start_ff;
  assign sysclkOut = clkOut_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // output level follows the half of the cycle
  property p_clkout_halves;
    ((phase_ff == PH_Q1) || (phase_ff == PH_Q2)) |-> !clkOut_ff;
  endproperty
  a_clkout_halves: assert property (p_clkout_halves) else $error("clock out high in Q1/Q2");
  property p_clkout_rise;
    $rose(clkOut_ff) |-> (phase_ff == PH_Q3);
  endproperty
  a_clkout_rise: assert property (p_clkout_rise) else $error("clock out rose outside Q3");
  property p_cycle_min;
    instrCycleStart |=> (!instrCycleStart) [*6];
  endproperty
  a_cycle_min: assert property (p_cycle_min) else $error("instruction cycle too short");
  c_cycle: cover property (instrCycleStart ##[1:600] instrCycleStart);
endmodule
`default_nettype wire

//--- orcd_config_loader.sv
// module: nonvolatile start-up configuration words, their latch and decode
//
// The strobed register port and the address map were left to the implementer.
`default_nettype none
module orcd_config_loader
  import orcd_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic powerOnRst, // reset is a power-on reset
  input wire logic [3:0] regAddr, // register address
  input wire logic [7:0] regWrData, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [7:0] regRdData, // read data, cycle after read
  input wire logic hvEntryPin, // high-voltage programming entry
  input wire logic lvEntryPin, // low-voltage programming entry
  input wire logic sharedInputPin, // shared reset / input pin level
  input wire logic sleepMode, // device is asleep
  output orcd_osc_cfg_t oscCfg, // decoded oscillator settings
  output orcd_rst_cfg_t rstCfg, // decoded reset settings
  output logic extResetReq, // external reset asserted
  output logic sharedInputData, // general input value
  output orcd_phase_t phase, // quarter phase
  output logic instrCycleStart, // instruction-cycle start pulse
  output logic sysclkOut // system clock output
);
  logic [2:0] pinSync;
  logic progHv, progLv, pinLevel;
  logic [7:0] oscNv_ff, nxt_oscNv, rstNv_ff, nxt_rstNv;
  logic [7:0] oscAct_ff, nxt_oscAct, rstAct_ff, nxt_rstAct;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic reject_ff, nxt_reject;
  logic [7:0] rdData_ff, nxt_rdData;
  orcd_osc_cfg_t oscCfg_ff, nxt_oscCfg;
  orcd_rst_cfg_t rstCfg_ff, nxt_rstCfg;
  logic extRst_ff, nxt_extRst, gpIn_ff, nxt_gpIn;
  logic [7:0] quarter_ff, nxt_quarter, oscPeriod, halfPeriod;
  logic nvWrite, lvOnly;
  logic [7:0] oscWr, rstWr;

  // programming entry pins and the shared pin cross into clk
  orcd_pin_sync #(.WIDTH(3)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn({sharedInputPin, lvEntryPin, hvEntryPin}),
    .pinOut(pinSync)
  );
  assign progHv = pinSync[0];
  assign progLv = pinSync[1];
  assign pinLevel = pinSync[2];

  // nonvolatile words: erased on power-on, written only in programming mode
  always_comb begin
    nvWrite = regWr && (progHv || progLv);
    lvOnly = progLv && !progHv;
    oscWr = regWrData & OSC_IMPL_MASK;
    rstWr = regWrData & RST_IMPL_MASK;
    if (lvOnly) begin
      rstWr[RST_MCLR_EN_BIT] = rstNv_ff[RST_MCLR_EN_BIT];
    end
    nxt_oscNv = oscNv_ff;
    nxt_rstNv = rstNv_ff;
    if (!rst_n && powerOnRst) begin
      nxt_oscNv = OSC_ERASED;
      nxt_rstNv = RST_ERASED;
    end else if (nvWrite && regAddr == ADDR_OSC_NV) begin
      nxt_oscNv = oscWr;
    end else if (nvWrite && regAddr == ADDR_RST_NV) begin
      nxt_rstNv = rstWr;
    end
  end

  // active copies follow the stored words only while reset is held
  always_comb begin
    nxt_oscAct = !rst_n ? oscNv_ff : oscAct_ff;
    nxt_rstAct = !rst_n ? rstNv_ff : rstAct_ff;
  end

  // control register and sticky reject flag, set beats clear
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_reject = reject_ff;
    if (regWr && regAddr == ADDR_CTRL) begin
      nxt_ctrl = regWrData & 8'h01;
    end
    if (regWr && regAddr == ADDR_STAT && regWrData[STAT_REJECT_BIT]) begin
      nxt_reject = 1'b0;
    end
    if (nvWrite && lvOnly && regAddr == ADDR_RST_NV &&
        regWrData[RST_MCLR_EN_BIT] != rstNv_ff[RST_MCLR_EN_BIT]) begin
      nxt_reject = 1'b1;
    end
  end

  // read mux: data stand for one cycle after the read strobe
  always_comb begin
    nxt_rdData = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        ADDR_OSC_NV: nxt_rdData = oscNv_ff;
        ADDR_RST_NV: nxt_rdData = rstNv_ff;
        ADDR_OSC_ACT: nxt_rdData = oscAct_ff;
        ADDR_RST_ACT: nxt_rdData = rstAct_ff;
        ADDR_CTRL: nxt_rdData = ctrl_ff;
        ADDR_STAT: begin
          nxt_rdData[STAT_HV_BIT] = progHv;
          nxt_rdData[STAT_LV_BIT] = progLv;
          nxt_rdData[STAT_REJECT_BIT] = reject_ff;
          nxt_rdData[STAT_BROWNOUT_BIT] = rstCfg_ff.brownoutActive;
          nxt_rdData[STAT_EXTRST_BIT] = extRst_ff;
        end
        default: nxt_rdData = 8'h00;
      endcase
    end
  end

  // oscillator word decode
  always_comb begin
    nxt_oscCfg.src = orcd_osc_src_t'(oscAct_ff[OSC_SEL_LSB +: 3]);
    nxt_oscCfg.usePll = (oscAct_ff[2:0] == OSRC_FASTRC_DIV_PLL) ||
                        (oscAct_ff[2:0] == OSRC_PRIMARY_PLL);
    nxt_oscCfg.usePostscaler = (oscAct_ff[2:0] == OSRC_FASTRC_DIV_PLL) ||
                               (oscAct_ff[2:0] == OSRC_FASTRC_DIV) ||
                               (oscAct_ff[2:0] == OSRC_LOWPWR_FASTRC_DIV);
    nxt_oscCfg.twoSpeed = oscAct_ff[OSC_TWO_SPEED_BIT];
    nxt_oscCfg.lowpwrRcHighPower = oscAct_ff[OSC_LOWPOWER_RC_OSC_POWER_BIT];
    nxt_oscCfg.secOscCrystal = oscAct_ff[OSC_SEC_SRC_BIT];
  end

  // reset word decode
  always_comb begin
    nxt_rstCfg.masterClearEn = rstAct_ff[RST_MCLR_EN_BIT];
    nxt_rstCfg.trip = orcd_trip_t'(rstAct_ff[RST_TRIP_LSB +: 2]);
    nxt_rstCfg.tripLowPower = (rstAct_ff[RST_TRIP_LSB +: 2] == TRIP_LOWPWR);
    nxt_rstCfg.i2cDefaultPins = rstAct_ff[RST_I2C_MAP_BIT] || !LARGE_PACKAGE;
    nxt_rstCfg.powerupTimerEn = rstAct_ff[RST_PWRUP_BIT];
    nxt_rstCfg.mode = orcd_bmode_t'(rstAct_ff[RST_MODE_LSB +: 2]);
    unique case (orcd_bmode_t'(rstAct_ff[RST_MODE_LSB +: 2]))
      BMODE_ALWAYS: nxt_rstCfg.brownoutActive = 1'b1;
      BMODE_AWAKE: nxt_rstCfg.brownoutActive = !sleepMode;
      BMODE_SOFTWARE: nxt_rstCfg.brownoutActive = ctrl_ff[CTRL_SW_BROWNOUT_BIT];
      BMODE_OFF: nxt_rstCfg.brownoutActive = 1'b0;
    endcase
  end

  // shared pin: external reset (low active) or general input
  always_comb begin
    nxt_extRst = rstAct_ff[RST_MCLR_EN_BIT] && !pinLevel;
    nxt_gpIn = !rstAct_ff[RST_MCLR_EN_BIT] && pinLevel;
  end

  // quarter length: half the time-base period, never below QUARTER_MIN clk cycles
  always_comb begin
    unique case (orcd_osc_src_t'(oscAct_ff[2:0]))
      OSRC_FASTRC: oscPeriod = OSCP_FASTRC;
      OSRC_FASTRC_DIV_PLL: oscPeriod = OSCP_FASTRC_PLL;
      OSRC_PRIMARY: oscPeriod = OSCP_PRIMARY;
      OSRC_PRIMARY_PLL: oscPeriod = OSCP_PRIMARY_PLL;
      OSRC_SECOSC: oscPeriod = OSCP_SECOSC;
      OSRC_LOWPWR_RC: oscPeriod = OSCP_LOWPWR_RC;
      OSRC_LOWPWR_FASTRC_DIV: oscPeriod = OSCP_LOWPWR_FASTRC;
      OSRC_FASTRC_DIV: oscPeriod = OSCP_FASTRC_DIV;
    endcase
    halfPeriod = {1'b0, oscPeriod[7:1]};
    nxt_quarter = (halfPeriod < QUARTER_MIN) ? QUARTER_MIN : halfPeriod;
  end

  // state registers
  always_ff @(posedge clk) begin
    oscNv_ff <= nxt_oscNv;
    rstNv_ff <= nxt_rstNv;
    oscAct_ff <= nxt_oscAct;
    rstAct_ff <= nxt_rstAct;
    if (!rst_n) begin
      ctrl_ff <= CTRL_RESET;
      reject_ff <= 1'b0;
      rdData_ff <= 8'h00;
      oscCfg_ff <= '0;
      rstCfg_ff <= '0;
      extRst_ff <= 1'b0;
      gpIn_ff <= 1'b0;
      quarter_ff <= QUARTER_MIN;
    end else begin
      ctrl_ff <= nxt_ctrl;
      reject_ff <= nxt_reject;
      rdData_ff <= nxt_rdData;
      oscCfg_ff <= nxt_oscCfg;
      rstCfg_ff <= nxt_rstCfg;
      extRst_ff <= nxt_extRst;
      gpIn_ff <= nxt_gpIn;
      quarter_ff <= nxt_quarter;
    end
  end

  // instruction-cycle sequencer on the selected time base
  orcd_cycle_gen u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .quarterDiv(quarter_ff),
    .phase(phase),
    .instrCycleStart(instrCycleStart),
    .sysclkOut(sysclkOut)
  );

  assign regRdData = rdData_ff;
  assign oscCfg = oscCfg_ff;
  assign rstCfg = rstCfg_ff;
  assign extResetReq = extRst_ff;
  assign sharedInputData = gpIn_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_fastrc_codes;
    (rst_n && oscAct_ff[2:0] == 3'h1) |=>
      oscCfg.usePll && oscCfg.usePostscaler && oscCfg.src == OSRC_FASTRC_DIV_PLL;
  endproperty
  a_fastrc_codes: assert property (p_fastrc_codes) else $error("fast RC PLL decode");
  property p_primary_pll;
    (rst_n && oscAct_ff[2:0] == 3'h3) |=> oscCfg.usePll && !oscCfg.usePostscaler;
  endproperty
  a_primary_pll: assert property (p_primary_pll) else $error("primary PLL decode");
  property p_osc_flags;
    rst_n |=> (oscCfg.twoSpeed == oscAct_ff[7]) && (oscCfg.lowpwrRcHighPower == oscAct_ff[6])
      && (oscCfg.secOscCrystal == oscAct_ff[5]);
  endproperty
  a_osc_flags: assert property (p_osc_flags) else $error("oscillator flag decode");
  property p_pin_split;
    rstCfg.masterClearEn |-> !sharedInputData;
  endproperty
  a_pin_split: assert property (p_pin_split) else $error("input live while reset pin");
  property p_lv_reject;
    (regWr && regAddr == ADDR_RST_NV && progLv && !progHv &&
      regWrData[7] != rstNv_ff[7]) |=> $stable(rstNv_ff[7]) && reject_ff;
  endproperty
  a_lv_reject: assert property (p_lv_reject) else $error("low-voltage change accepted");
  property p_trip_lowpwr;
    (rst_n && rstAct_ff[6:5] == 2'h0) |=> rstCfg.tripLowPower;
  endproperty
  a_trip_lowpwr: assert property (p_trip_lowpwr) else $error("low-power trip decode");
  property p_i2c_map;
    (!rstAct_ff[4] && LARGE_PACKAGE) |=> !rstCfg.i2cDefaultPins;
  endproperty
  a_i2c_map: assert property (p_i2c_map) else $error("alternate I2C map lost");
  property p_pwrup;
    rst_n |=> rstCfg.powerupTimerEn == $past(rstAct_ff[3]);
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("power-up timer decode");
  property p_sw_mode;
    (rstAct_ff[1:0] == 2'h1 && !ctrl_ff[0]) |=> !rstCfg.brownoutActive;
  endproperty
  a_sw_mode: assert property (p_sw_mode) else $error("software brown-out ignored");
  property p_hold;
    rst_n ##1 rst_n |-> $stable(oscAct_ff) && $stable(rstAct_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("active words changed out of reset");
  // decode, pin split, brown-out and read checks one cycle after the source; quarter floor checked every cycle
  property p_lowpower_rc_osc_power;
    rst_n |=> oscCfg.lowpwrRcHighPower == $past(oscAct_ff[OSC_LOWPOWER_RC_OSC_POWER_BIT]);
  endproperty
  a_lowpower_rc_osc_power: assert property (p_lowpower_rc_osc_power) else $error("low-power RC power decode");
  property p_sec_osc;
    rst_n |=> oscCfg.secOscCrystal == $past(oscAct_ff[OSC_SEC_SRC_BIT]);
  endproperty
  a_sec_osc: assert property (p_sec_osc) else $error("secondary oscillator source decode");
  property p_src_code;
    rst_n |=> oscCfg.src == $past(oscAct_ff[OSC_SEL_LSB +: 3]);
  endproperty
  a_src_code: assert property (p_src_code) else $error("start-up source decode");
  property p_ext_reset;
    rst_n |=> extResetReq == ($past(rstAct_ff[RST_MCLR_EN_BIT]) && !$past(pinLevel));
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("external reset request wrong");
  property p_awake_sleep;
    (rst_n && rstAct_ff[1:0] == 2'h2 && sleepMode) |=> !rstCfg.brownoutActive;
  endproperty
  a_awake_sleep: assert property (p_awake_sleep) else $error("brown-out on in sleep");
  property p_always_on;
    (rst_n && rstAct_ff[1:0] == 2'h3) |=> rstCfg.brownoutActive;
  endproperty
  a_always_on: assert property (p_always_on) else $error("brown-out not always on");
  property p_quarter_floor;
    quarter_ff >= QUARTER_MIN;
  endproperty
  a_quarter_floor: assert property (p_quarter_floor) else $error("quarter below minimum");
  property p_rd_stands;
    !regRd |=> regRdData == 8'h00;
  endproperty
  a_rd_stands: assert property (p_rd_stands) else $error("read data outside read cycle");
  c_hv_write: cover property (regWr && regAddr == ADDR_RST_NV && progHv);
  c_reject: cover property ($rose(reject_ff));
  c_awake_mode: cover property (rstCfg.mode == BMODE_AWAKE && sleepMode);
endmodule
`default_nettype wire

//--- orcd_prog_model.sv
// programmer model: drives the register port and the programming entry pins
`default_nettype none
module orcd_prog_model (
  input wire logic clk, // system clock
  output logic [3:0] regAddr, // register address
  output logic [7:0] regWrData, // write data
  output logic regWr, // write strobe
  output logic regRd, // read strobe
  input wire logic [7:0] regRdData, // read data, cycle after strobe
  output logic hvEntryPin, // high-voltage programming entry
  output logic lvEntryPin // low-voltage programming entry
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    hvEntryPin = 1'b0;
    lvEntryPin = 1'b0;
  end

  // one-cycle write; released lines show inverted values
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask

  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdData;
  endtask

  // entry pins; master-clear changes are meant for high-voltage entry only
  task automatic entry(input logic hv, input logic lv);
    @(posedge clk);
    hvEntryPin <= hv;
    lvEntryPin <= lv;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- orcd_tb.sv
// testbench: start-up configuration decoder driven through a programmer model
`default_nettype none
module tb import orcd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic powerOnRst = 1'b1;
  logic sharedInputPin = 1'b1;
  logic sleepMode = 1'b0;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic regWr, regRd, hvEntryPin, lvEntryPin;
  orcd_osc_cfg_t oscCfg;
  orcd_rst_cfg_t rstCfg;
  logic extResetReq, sharedInputData, instrCycleStart, sysclkOut;
  orcd_phase_t phase;
  int err_total = 0;
  int n_compared = 0;
  logic [7:0] rdv, v;
  logic [8:0] ev;
  int hi, lo, q;
  int ncyc;
  logic [3:0] phs;
  logic [7:0] perTab [8] = '{OSCP_FASTRC, OSCP_FASTRC_PLL, OSCP_PRIMARY, OSCP_PRIMARY_PLL,
    OSCP_SECOSC, OSCP_LOWPWR_RC, OSCP_LOWPWR_FASTRC, OSCP_FASTRC_DIV};
  logic [7:0] rstTab [4] = '{8'hFB, 8'h5A, 8'h21, 8'h80};

  always #5 clk = ~clk;

  orcd_config_loader u_dut (.clk(clk), .rst_n(rst_n), .powerOnRst(powerOnRst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .hvEntryPin(hvEntryPin), .lvEntryPin(lvEntryPin),
    .sharedInputPin(sharedInputPin), .sleepMode(sleepMode), .oscCfg(oscCfg),
    .rstCfg(rstCfg), .extResetReq(extResetReq), .sharedInputData(sharedInputData),
    .phase(phase), .instrCycleStart(instrCycleStart), .sysclkOut(sysclkOut));

  orcd_prog_model u_prog (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .hvEntryPin(hvEntryPin),
    .lvEntryPin(lvEntryPin));

  // value comparison
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // reset pulse of four cycles, then settle time for pins
  task automatic do_reset(input logic por);
    rst_n <= 1'b0;
    powerOnRst <= por;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    powerOnRst <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask

  // store a word under high-voltage entry, then reset to load it
  task automatic load(input logic [3:0] a, input logic [7:0] d);
    u_prog.entry(1'b1, 1'b0);
    u_prog.wr(a, d);
    u_prog.entry(1'b0, 1'b0);
    do_reset(1'b0);
  endtask

  // length of one high and one low half of the clock output
  task automatic halves(output int h, output int l);
    int n;
    n = 0;
    h = 0;
    l = 0;
    while (sysclkOut !== 1'b0 && n < 1200) begin @(posedge clk); #1; n++; end
    while (sysclkOut !== 1'b1 && n < 1200) begin @(posedge clk); #1; n++; end
    while (sysclkOut === 1'b1 && n < 1200) begin @(posedge clk); #1; n++; h++; end
    while (sysclkOut === 1'b0 && n < 1200) begin @(posedge clk); #1; n++; l++; end
  endtask

  // cycles between two instruction-cycle starts, and the phase at a start
  task automatic cyc(output int n, output logic [3:0] ph);
    int k;
    k = 0;
    n = 0;
    ph = 4'h0;
    while (instrCycleStart !== 1'b1 && k < 1200) begin @(posedge clk); #1; k++; end
    ph = phase;
    do begin @(posedge clk); #1; n++; end while (instrCycleStart !== 1'b1 && n < 1200);
  endtask

  // expected oscillator decode of a stored word
  function automatic logic [7:0] expOsc(input logic [7:0] w);
    return {w[2:0], (w[2:0] == 3'h1) || (w[2:0] == 3'h3),
      (w[2:0] == 3'h1) || (w[2:0] == 3'h6) || (w[2:0] == 3'h7), w[7], w[6], w[5]};
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #200us;
    err_total++;
    wrap_up();
  end

  initial begin
    do_reset(1'b1);
    u_prog.rd(4'h0, rdv);
    chk("osc erased", 16'hE1, 16'(rdv));
    u_prog.rd(4'h1, rdv);
    chk("reset erased", 16'hFB, 16'(rdv));
    chk("osc decode erased", 16'(expOsc(8'hE1)), 16'(oscCfg));
    $display("test erased done");
    for (int c = 0; c < 8; c++) begin
      v = {3'(c) ^ 3'h5, 2'h0, 3'(c)};
      load(4'h0, v);
      chk("osc decode", 16'(expOsc(v)), 16'(oscCfg));
      u_prog.rd(4'h2, rdv);
      chk("osc active", 16'(v), 16'(rdv));
      q = (perTab[c] / 2 > QUARTER_MIN) ? perTab[c] / 2 : QUARTER_MIN;
      halves(hi, lo);
      chk("sysclk high", 16'(2 * q), 16'(hi));
      chk("sysclk low", 16'(2 * q), 16'(lo));
      cyc(ncyc, phs);
      chk("cycle length", 16'(4 * q), 16'(ncyc));
      chk("phase at cycle start", 16'(PH_Q1), 16'(phs));
    end
    $display("test oscillator select done");
    for (int i = 0; i < 4; i++) begin
      v = rstTab[i];
      load(4'h1, v);
      ev = {v[7], v[6:5], v[6:5] == 2'h0, v[4], v[3], v[1:0], v[1:0] == 2'h3 || v[1:0] == 2'h2};
      chk("reset decode awake", 16'(ev), 16'(rstCfg));
      u_prog.wr(4'h4, 8'h01);
      sleepMode <= 1'b1;
      sharedInputPin <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      ev[0] = (v[1:0] == 2'h3) || (v[1:0] == 2'h1);
      chk("reset decode asleep", 16'(ev), 16'(rstCfg));
      chk("ext reset pin low", 16'(v[7]), 16'(extResetReq));
      chk("input pin low", 16'h0, 16'(sharedInputData));
      sharedInputPin <= 1'b1;
      sleepMode <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      chk("ext reset pin high", 16'h0, 16'(extResetReq));
      chk("input pin high", 16'(!v[7]), 16'(sharedInputData));
    end
    $display("test reset word done");
    u_prog.entry(1'b0, 1'b1);
    u_prog.wr(4'h1, 8'h00);
    u_prog.rd(4'h1, rdv);
    chk("low-voltage keeps master clear", 16'h80, 16'(rdv));
    u_prog.rd(4'h5, rdv);
    chk("reject flag", 16'h06, 16'(rdv & 8'h07));
    u_prog.wr(4'h5, 8'h04);
    u_prog.rd(4'h5, rdv);
    chk("reject cleared", 16'h00, 16'(rdv & 8'h04));
    u_prog.entry(1'b1, 1'b0);
    u_prog.wr(4'h1, 8'h00);
    u_prog.rd(4'h1, rdv);
    chk("high-voltage changes master clear", 16'h00, 16'(rdv));
    u_prog.rd(4'h3, rdv);
    chk("active word held", 16'h80, 16'(rdv));
    chk("master clear held", 16'h1, 16'(rstCfg.masterClearEn));
    u_prog.wr(4'h0, 8'hFF);
    u_prog.rd(4'h0, rdv);
    chk("osc unimplemented bits", 16'hE7, 16'(rdv));
    u_prog.rd(4'hF, rdv);
    chk("unmapped read", 16'h00, 16'(rdv));
    u_prog.entry(1'b0, 1'b0);
    u_prog.wr(4'h0, 8'h00);
    u_prog.rd(4'h0, rdv);
    chk("write without entry", 16'hE7, 16'(rdv));
    $display("test programming entry done");
    wrap_up();
  end
endmodule
`default_nettype wire
